// ==== hw/pcrvd_pkg.sv ====
package pcrvd_pkg;
    // ==========================================================
    // register offsets and pages
    // ==========================================================
    localparam logic [7:0] PAGE_SELECT_OFS     = 8'h00;
    localparam logic [7:0] VD_CFG1_OFS         = 8'h1E;
    localparam logic [7:0] VD_CFG2_OFS         = 8'h1F;
    localparam logic [7:0] POWER_CFG_OFS       = 8'h75;
    localparam logic [7:0] CHECKSUM_OFS        = 8'h7E;
    localparam logic [7:0] LAST_OFS            = 8'h7F;
    localparam logic [7:0] COEF_FIRST_OFS      = 8'h08;
    localparam logic [7:0] PAGE_ZERO           = 8'h00;
    localparam logic [7:0] PAGE_ONE            = 8'h01;
    localparam logic [7:0] COEF_PAGE_LO        = 8'h02;
    localparam logic [7:0] COEF_PAGE_HI        = 8'h04;
    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] PAGE_SELECT_RST     = 8'h00;
    localparam logic [7:0] VD_CFG1_RST         = 8'h20;
    localparam logic [7:0] VD_CFG2_RST         = 8'h08;
    localparam logic [7:0] POWER_CFG_RST       = 8'h00;
    localparam logic [7:0] CHECKSUM_RST        = 8'h00;
    // writable bits of the second config; 5 and 2-0 read as reset
    localparam logic [7:0] VD_CFG2_WMASK       = 8'hD8;
    // ==========================================================
    // field positions
    // ==========================================================
    localparam int POLICY_HI   = 7;
    localparam int POLICY_LO   = 6;
    localparam int CHAN_HI     = 5;
    localparam int CHAN_LO     = 4;
    localparam int CLKSRC_HI   = 3;
    localparam int CLKSRC_LO   = 2;
    localparam int FREQ_HI     = 1;
    localparam int FREQ_LO     = 0;
    localparam int DET_EN_BIT  = 0;
    localparam int CONV_ON_BIT = 6;
    // ==========================================================
    // field encodings
    // ==========================================================
    typedef enum logic [1:0] {
        PCRVD_POL_USER     = 2'b00,
        PCRVD_POL_DETECT   = 2'b01,
        PCRVD_POL_DET_UP   = 2'b10,
        PCRVD_POL_DET_DOWN = 2'b11
    } pcrvd_policy_type;
    typedef enum logic [1:0] {
        PCRVD_CLK_OSC    = 2'b00,
        PCRVD_CLK_BIT    = 2'b01,
        PCRVD_CLK_MASTER = 2'b10,
        PCRVD_CLK_CUSTOM = 2'b11
    } pcrvd_clksrc_type;
endpackage

// ==== hw/pcrvd_checksum.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// running transaction checksum
// ==========================================================
module pcrvd_checksum
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // write strobes
    input  wire logic       load_en,
    input  wire logic       accum_en,
    input  wire logic [7:0] wr_data,
    // running value
    output logic      [7:0] sum_q
);
    import pcrvd_pkg::*;

    // preload wins over accumulation; they never coincide anyway
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sum_q <= CHECKSUM_RST;
        else if (load_en)
            sum_q <= wr_data;
        else if (accum_en)
            sum_q <= 8'(sum_q + wr_data);
    end
endmodule
`default_nettype wire

// ==== hw/pcrvd_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// paged configuration registers with voice-detect setup
// ==========================================================
module pcrvd_regs
(
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    // register access from the serial-control front end
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic                         reg_autoinc,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    output logic      [7:0]                   reg_rdata,
    output logic                              reg_rvalid,
    output logic      [7:0]                   reg_next_addr,
    // page and checksum state
    output logic      [7:0]                   cur_page,
    output logic      [7:0]                   checksum,
    // detector configuration
    output pcrvd_pkg::pcrvd_policy_type       detect_power_policy,
    output logic      [1:0]                   detect_channel_select,
    output pcrvd_pkg::pcrvd_clksrc_type       detect_clock_source,
    output logic      [1:0]                   detect_ext_clock_freq,
    output logic                              detect_clk_follow_main,
    output logic      [7:0]                   detect_config_2,
    // power control
    output logic                              detect_enable,
    output logic                              converter_power_on
);
    import pcrvd_pkg::*;

    // ==========================================================
    // storage
    // ==========================================================
    logic [7:0] page_q;          // current page selector
    logic [7:0] cfg1_q;          // first detector configuration
    logic [7:0] cfg2_q;          // second detector configuration
    logic [7:0] pwr_q;           // page-0 power configuration
    logic [7:0] sum_w;           // checksum from the accumulator
    logic [7:0] rdata_q;         // registered read data
    logic       rvalid_q;        // read answer strobe
    logic [7:0] next_addr_q;     // address after this access
    logic [7:0] page_d;          // page after this access

    // ==========================================================
    // decode helpers
    // ==========================================================
    // true when offset addr on page pg is the given location
    function automatic logic hit(input logic [7:0] pg, input logic [7:0] addr,
                                 input logic [7:0] want_pg, input logic [7:0] want_ofs);
        hit = (pg == want_pg) && (addr == want_ofs);
    endfunction

    logic wr_page;               // page selector write, any page
    logic wr_sum;                // checksum write, page 0
    logic wr_cfg1;               // first config write
    logic wr_cfg2;               // second config write
    logic wr_pwr;                // power config write
    logic coef_page;             // page with page-wrapping auto-increment
    logic wrap;                  // auto-increment access at last offset of a coefficient page wraps

    // page selector sits at offset zero whatever the page
    assign wr_page   = reg_wr && (reg_addr == PAGE_SELECT_OFS);
    assign wr_sum    = reg_wr && hit(page_q, reg_addr, PAGE_ZERO, CHECKSUM_OFS);
    assign wr_cfg1   = reg_wr && hit(page_q, reg_addr, PAGE_ONE, VD_CFG1_OFS);
    assign wr_cfg2   = reg_wr && hit(page_q, reg_addr, PAGE_ONE, VD_CFG2_OFS);
    assign wr_pwr    = reg_wr && hit(page_q, reg_addr, PAGE_ZERO, POWER_CFG_OFS);
    assign coef_page = (page_q >= COEF_PAGE_LO) && (page_q <= COEF_PAGE_HI);
    assign wrap      = reg_autoinc && coef_page && (reg_addr == LAST_OFS);

    // ==========================================================
    // checksum accumulator
    // ==========================================================
    // every write other than the checksum itself feeds it, on all pages;
    // writes to reserved offsets still count, the host owns that risk
    pcrvd_checksum u_checksum
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .load_en  (wr_sum),
        .accum_en (reg_wr && !wr_sum),
        .wr_data  (reg_wdata),
        .sum_q    (sum_w)
    );

    // ==========================================================
    // page selector
    // ==========================================================
    always_comb
    begin
        page_d = page_q;
        if (wr_page)
            page_d = reg_wdata;
        else if ((reg_wr || reg_rd) && wrap)
            page_d = 8'(page_q + 8'h01);
    end

    // reset puts the host back on page zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            page_q <= PAGE_SELECT_RST;
        else
            page_q <= page_d;
    end

    // ==========================================================
    // auto-increment address
    // ==========================================================
    // the front end takes this as its next offset for burst transfers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            next_addr_q <= PAGE_SELECT_OFS;
        else if (reg_wr || reg_rd)
        begin
            if (wrap)
                next_addr_q <= COEF_FIRST_OFS;
            else
                next_addr_q <= 8'(reg_addr + 8'h01);
        end
    end

    // ==========================================================
    // detector configuration
    // ==========================================================
    // unlisted page-1 offsets hold no storage; host must not write them
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg1_q <= VD_CFG1_RST;
        else if (wr_cfg1)
            cfg1_q <= reg_wdata;
    end

    // read-only bits keep reset value so reads stay stable
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg2_q <= VD_CFG2_RST;
        else if (wr_cfg2)
            cfg2_q <= (reg_wdata & VD_CFG2_WMASK) | (VD_CFG2_RST & ~VD_CFG2_WMASK);
    end

    // ==========================================================
    // page-0 power configuration
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pwr_q <= POWER_CFG_RST;
        else if (wr_pwr)
            pwr_q <= reg_wdata;
    end

    // ==========================================================
    // read path
    // ==========================================================
    // one-cycle latency; unmapped offsets read as zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd;
            if (!reg_rd)
                rdata_q <= rdata_q;
            else if (reg_addr == PAGE_SELECT_OFS)
                rdata_q <= page_q;
            else if (hit(page_q, reg_addr, PAGE_ZERO, CHECKSUM_OFS))
                rdata_q <= sum_w;
            else if (hit(page_q, reg_addr, PAGE_ZERO, POWER_CFG_OFS))
                rdata_q <= pwr_q;
            else if (hit(page_q, reg_addr, PAGE_ONE, VD_CFG1_OFS))
                rdata_q <= cfg1_q;
            else if (hit(page_q, reg_addr, PAGE_ONE, VD_CFG2_OFS))
                rdata_q <= cfg2_q;
            else
                rdata_q <= 8'h00;
        end
    end

    // ==========================================================
    // registered field outputs
    // ==========================================================
    // decoded copies lag the storage by one cycle, keeping outputs flopped
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            // cfg1 field copies start from the packed reset word; the follow flag and power bits are hand-typed zeros
            detect_power_policy    <= pcrvd_policy_type'(VD_CFG1_RST[POLICY_HI:POLICY_LO]);
            detect_channel_select  <= VD_CFG1_RST[CHAN_HI:CHAN_LO];
            detect_clock_source    <= pcrvd_clksrc_type'(VD_CFG1_RST[CLKSRC_HI:CLKSRC_LO]);
            detect_ext_clock_freq  <= VD_CFG1_RST[FREQ_HI:FREQ_LO];
            detect_clk_follow_main <= 1'b0;
            detect_config_2        <= VD_CFG2_RST;
            detect_enable          <= 1'b0;
            converter_power_on     <= 1'b0;
            cur_page               <= PAGE_SELECT_RST;
            checksum               <= CHECKSUM_RST;
        end
        else
        begin
            detect_power_policy    <= pcrvd_policy_type'(cfg1_q[POLICY_HI:POLICY_LO]);
            detect_channel_select  <= cfg1_q[CHAN_HI:CHAN_LO];
            detect_clock_source    <= pcrvd_clksrc_type'(cfg1_q[CLKSRC_HI:CLKSRC_LO]);
            detect_ext_clock_freq  <= cfg1_q[FREQ_HI:FREQ_LO];
            detect_clk_follow_main <= (cfg1_q[CLKSRC_HI:CLKSRC_LO] == PCRVD_CLK_CUSTOM);
            detect_config_2        <= cfg2_q;
            detect_enable          <= pwr_q[DET_EN_BIT];
            converter_power_on     <= pwr_q[CONV_ON_BIT];
            cur_page               <= page_q;
            checksum               <= sum_w;
        end
    end

    assign reg_rdata     = rdata_q;
    assign reg_rvalid    = rvalid_q;
    assign reg_next_addr = next_addr_q;
endmodule
`default_nettype wire

// ==== sim/pcrvd_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker for the paged register block
// ==========================================================
module pcrvd_checker
    import pcrvd_pkg::*;
(
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       reset,
    // register access
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic                       reg_autoinc,
    input wire logic [7:0]                 reg_addr,
    input wire logic [7:0]                 reg_wdata,
    input wire logic [7:0]                 reg_rdata,
    input wire logic                       reg_rvalid,
    input wire logic [7:0]                 reg_next_addr,
    // page, checksum and detector fields
    input wire logic [7:0]                 cur_page,
    input wire logic [7:0]                 checksum,
    input wire pcrvd_pkg::pcrvd_policy_type detect_power_policy,
    input wire logic [1:0]                 detect_channel_select,
    input wire pcrvd_pkg::pcrvd_clksrc_type detect_clock_source,
    input wire logic [1:0]                 detect_ext_clock_freq,
    input wire logic                       detect_clk_follow_main
);
    logic [1:0] wr_hist_q;  // writes seen at the last two edges
    logic       quiet;      // page and checksum copies have caught up
    // outputs lag storage, so page-dependent relations are only judged after two idle edges
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            wr_hist_q <= 2'h0;
        else
            wr_hist_q <= {wr_hist_q[0], reg_wr};
    end
    assign quiet = (wr_hist_q == 2'h0);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_no_stray: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
        else $error("read answer without a read");
    a_cksum_load: assert property (reg_wr && quiet && cur_page == PAGE_ZERO
        && reg_addr == CHECKSUM_OFS |-> ##2 checksum == $past(reg_wdata, 2))
        else $error("checksum not loaded");
    a_cksum_sum: assert property (reg_wr && quiet && !(cur_page == PAGE_ZERO
        && reg_addr == CHECKSUM_OFS)
        |-> ##2 checksum == 8'($past(checksum, 2) + $past(reg_wdata, 2)))
        else $error("checksum not accumulated");
    a_page_write: assert property (reg_wr && reg_addr == PAGE_SELECT_OFS
        |-> ##2 cur_page == $past(reg_wdata, 2))
        else $error("page selector not written");
    a_cfg1_fields: assert property (reg_wr && quiet && cur_page == PAGE_ONE
        && reg_addr == VD_CFG1_OFS |-> ##2 {detect_power_policy, detect_channel_select,
        detect_clock_source, detect_ext_clock_freq} == $past(reg_wdata, 2))
        else $error("detector fields wrong");
    a_follow_main: assert property (reg_wr && quiet && cur_page == PAGE_ONE
        && reg_addr == VD_CFG1_OFS |-> ##2 detect_clk_follow_main
        == ($past(reg_wdata[3:2], 2) == 2'b11))
        else $error("clock follow flag wrong");
    a_page_wrap: assert property (reg_autoinc && (reg_wr || reg_rd) && quiet
        && reg_addr == LAST_OFS && cur_page >= COEF_PAGE_LO && cur_page <= COEF_PAGE_HI
        |=> reg_next_addr == COEF_FIRST_OFS ##1 cur_page == 8'($past(cur_page, 2) + 1))
        else $error("coefficient page wrap wrong");
    c_read: cover property (reg_rvalid);
    c_wrap: cover property (reg_autoinc && reg_rd && reg_addr == LAST_OFS);
    c_cfg1: cover property (reg_wr && cur_page == PAGE_ONE && reg_addr == VD_CFG1_OFS);
endmodule
bind pcrvd_regs pcrvd_checker chk (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_autoinc,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_next_addr, .cur_page, .checksum,
    .detect_power_policy, .detect_channel_select, .detect_clock_source,
    .detect_ext_clock_freq, .detect_clk_follow_main);
`default_nettype wire

// ==== sim/pcrvd_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// serial-control host model, one byte per access
// ==========================================================
module pcrvd_host
(
    // clock
    input  wire logic       sys_clk,
    // register access
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic       reg_autoinc,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial
    begin
        {reg_wr, reg_rd, reg_autoinc, reg_addr, reg_wdata} = '0;
    end
    // callers never aim at unlisted page-1 offsets
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ai);
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_autoinc, reg_wr} = {a, d, ai, 1'b1};
        @(negedge sys_clk);
        // released lines show junk, not the last byte
        {reg_addr, reg_wdata, reg_autoinc, reg_wr} = {~a, ~d, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v, input logic ai);
        @(negedge sys_clk);
        {reg_addr, reg_autoinc, reg_rd} = {a, ai, 1'b1};
        @(negedge sys_clk);
        q = reg_rdata;
        v = reg_rvalid;
        {reg_addr, reg_autoinc, reg_rd} = {~a, 1'b0, 1'b0};
    endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pcrvd_pkg::*;
    // ==========================================================
    // signals and counters
    // ==========================================================
    logic             sys_clk = 1'b0;
    logic             reset = 1'b1;
    logic             reg_wr, reg_rd, reg_autoinc, reg_rvalid, v;
    logic             detect_clk_follow_main, detect_enable, converter_power_on;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata, reg_next_addr, q, sum;
    logic [7:0]       cur_page, checksum, detect_config_2;
    logic [1:0]       detect_channel_select, detect_ext_clock_freq;
    pcrvd_policy_type detect_power_policy;
    pcrvd_clksrc_type detect_clock_source;
    int               miscompares = 0;
    int               n_tests = 0;
    int               cycles = 0;
    pcrvd_regs dut (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_autoinc, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .reg_next_addr, .cur_page, .checksum,
        .detect_power_policy, .detect_channel_select, .detect_clock_source,
        .detect_ext_clock_freq, .detect_clk_follow_main, .detect_config_2,
        .detect_enable, .converter_power_on);
    pcrvd_host host (.sys_clk, .reg_wr, .reg_rd, .reg_autoinc, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    // a hang costs one mismatch and ends the run
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] cfg1_out;
        return {detect_power_policy, detect_channel_select, detect_clock_source,
            detect_ext_clock_freq};
    endfunction
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset;
        chk("page", 8'h00, cur_page);
        chk("fields", 8'h20, cfg1_out());
        chk("cfg2 out", 8'h08, detect_config_2);
        host.wr(8'h00, 8'h01, 1'b0);
        host.rd(8'h1E, q, v, 1'b0);
        chk("cfg1 read", 8'h20, q);
        host.rd(8'h1F, q, v, 1'b0);
        chk("cfg2 read", 8'h08, q);
        $display("test reset done");
    endtask
    // every code of every field, all-ones selects the page-0 clock settings
    task automatic t_cfg1;
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'h1E, 8'(i * 8'h55), 1'b0);
            repeat (3) @(negedge sys_clk);
            chk("fields", 8'(i * 8'h55), cfg1_out());
            chk("follow", {7'h00, i == 3}, {7'h00, detect_clk_follow_main});
            host.rd(8'h1E, q, v, 1'b0);
            chk("cfg1 read", 8'(i * 8'h55), q);
            chk("rvalid", 8'h01, {7'h00, v});
        end
        // all ones into the second config: read-only bits must stay at reset
        host.wr(8'h1F, 8'hFF, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk("cfg2 out", 8'hD8, detect_config_2);
        host.rd(8'h1F, q, v, 1'b0);
        chk("cfg2 read", 8'hD8, q);
        $display("test cfg1 done");
    endtask
    task automatic t_cksum;
        // the 0x50 write on page 0xFF shows the sum counts on every page
        logic [7:0] a [4] = '{8'h00, 8'h50, 8'h00, 8'h50};
        logic [7:0] d [4] = '{8'hFF, 8'h11, 8'h00, 8'h33};
        host.wr(8'h00, 8'h00, 1'b0);
        // idle edges so the load is judged with settled page copies
        repeat (2) @(negedge sys_clk);
        host.wr(8'h7E, 8'hF0, 1'b0);
        host.rd(8'h7E, q, v, 1'b0);
        chk("cksum load", 8'hF0, q);
        sum = 8'hF0;
        for (int i = 0; i < 4; i++)
        begin
            host.wr(a[i], d[i], 1'b0);
            sum = 8'(sum + d[i]);
        end
        host.rd(8'h7E, q, v, 1'b0);
        chk("cksum read", sum, q);
        chk("cksum out", sum, checksum);
        host.rd(8'h50, q, v, 1'b0);
        chk("unmapped", 8'h00, q);
        $display("test checksum done");
    endtask
    task automatic t_power;
        for (int i = 0; i < 2; i++)
        begin
            host.wr(8'h75, i ? 8'h40 : 8'h01, 1'b0);
            repeat (3) @(negedge sys_clk);
            chk("detect on", {7'h00, i == 0}, {7'h00, detect_enable});
            chk("conv on", {7'h00, i == 1}, {7'h00, converter_power_on});
        end
        $display("test power done");
    endtask
    task automatic t_wrap;
        host.rd(8'h7F, q, v, 1'b1);
        repeat (3) @(negedge sys_clk);
        chk("no wrap", 8'h00, cur_page);
        host.wr(8'h00, 8'h02, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            host.rd(8'h7F, q, v, 1'b1);
            chk("next addr", 8'h08, reg_next_addr);
            repeat (3) @(negedge sys_clk);
            chk("wrap page", 8'(3 + i), cur_page);
        end
        $display("test wrap done");
    endtask
    initial
    begin
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        t_reset();
        t_cfg1();
        t_cksum();
        t_power();
        t_wrap();
        print_verdict();
    end
endmodule
`default_nettype wire
